// *** core/lrp_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// LCD regulator power control
// ****************************************************************
module lrp_top #(
	parameter bit          HAS_LCD_REG = 1'b1,
	parameter int unsigned SETTLE_CYC  = lrp_pkg::SETTLE_CYC
) (
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic [15:0]         reg_addr,
	input  wire logic [3:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [3:0]               reg_rdata,
	output lrp_pkg::lrp_ctrl_t       ctrl,
	output lrp_pkg::lrp_levels_t     lcd_drive_levels,
	output logic                     boost_clk,
	output logic                     core_supply_out,
	output logic                     levels_settled
);
	logic [3:0] pwr_q;
	logic [3:0] frm_q;
	logic       boost_tick;
	logic [$clog2(SETTLE_CYC + 1)-1:0] settle_q;

	// Address match helper
	function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
		return a == r;
	endfunction

	// Power control register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q <= lrp_pkg::PWR_CTRL_RST;
		end else if (reg_wr && hit(reg_addr, lrp_pkg::PWR_CTRL_ADDR)) begin
			pwr_q <= reg_wdata;
		end
	end

	// Frame and boost clock select register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			frm_q <= lrp_pkg::FRAME_CLK_RST;
		end else if (reg_wr && hit(reg_addr, lrp_pkg::FRAME_CLK_ADDR)) begin
			frm_q <= reg_wdata;
		end
	end

	// Read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 4'h0;
		end else if (reg_rd && hit(reg_addr, lrp_pkg::PWR_CTRL_ADDR)) begin
			reg_rdata <= pwr_q;
		end else if (reg_rd && hit(reg_addr, lrp_pkg::FRAME_CLK_ADDR)) begin
			reg_rdata <= frm_q;
		end else begin
			reg_rdata <= 4'h0;
		end
	end

	// Control outputs to the analog regulators
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '0;
		end else begin
			ctrl.lcd_regulator_on       <= pwr_q[lrp_pkg::PWR_ON_BIT] & HAS_LCD_REG;
			ctrl.reference_level_select <= pwr_q[lrp_pkg::REF_SEL_BIT];
			ctrl.core_reg_heavy_load    <= pwr_q[lrp_pkg::CORE_HL_BIT];
			ctrl.lcd_reg_heavy_load     <= pwr_q[lrp_pkg::LCD_HL_BIT] & HAS_LCD_REG;
			ctrl.boost_clock_select     <= frm_q[lrp_pkg::BOOST_LSB +: 2];
			ctrl.frame_rate_select      <= frm_q[lrp_pkg::FRAME_LSB +: 2];
		end
	end

	// Drive levels forced to ground while the regulator is off
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lcd_drive_levels <= '0;
		end else if (pwr_q[lrp_pkg::PWR_ON_BIT] && HAS_LCD_REG) begin
			lcd_drive_levels <= '1;
		end else begin
			lcd_drive_levels <= '0;
		end
	end

	// Core regulator never switched off
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_supply_out <= 1'b1;
		end else begin
			core_supply_out <= 1'b1;
		end
	end

	// Boost clock runs only on the legal code one
	lrp_boost_div #(
		.HALF(lrp_pkg::BOOST_HALF)
	) u_div (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.run     (frm_q[lrp_pkg::BOOST_LSB +: 2] == lrp_pkg::BOOST_ON),
		.tick    (boost_tick)
	);

	// Boost clock toggle, stopped low otherwise
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			boost_clk <= 1'b0;
		end else if (frm_q[lrp_pkg::BOOST_LSB +: 2] != lrp_pkg::BOOST_ON) begin
			boost_clk <= 1'b0;
		end else if (boost_tick) begin
			boost_clk <= ~boost_clk;
		end
	end

	// Settling timer after switch-on, a status aid for software
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_q       <= '0;
			levels_settled <= 1'b0;
		end else if (!(pwr_q[lrp_pkg::PWR_ON_BIT] && HAS_LCD_REG)) begin
			settle_q       <= '0;
			levels_settled <= 1'b0;
		end else if (settle_q == $bits(settle_q)'(SETTLE_CYC)) begin
			levels_settled <= 1'b1;
		end else begin
			settle_q <= settle_q + $bits(settle_q)'(1);
		end
	end
endmodule

`default_nettype wire

// *** core/lrp_pkg.sv ***
`default_nettype none

package lrp_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [15:0] PWR_CTRL_ADDR  = 16'hff03;
	localparam logic [15:0] FRAME_CLK_ADDR = 16'hff12;
	localparam logic [3:0]  PWR_CTRL_RST   = 4'h0;
	localparam logic [3:0]  FRAME_CLK_RST  = 4'h0;

	// Field positions
	localparam int PWR_ON_BIT    = 0;
	localparam int REF_SEL_BIT   = 1;
	localparam int CORE_HL_BIT   = 2;
	localparam int LCD_HL_BIT    = 3;
	localparam int BOOST_LSB     = 0;
	localparam int FRAME_LSB     = 2;

	// Boost field codes
	localparam logic [1:0] BOOST_OFF = 2'h0;
	localparam logic [1:0] BOOST_ON  = 2'h1;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ      = 25000000;
	localparam int BOOST_HZ    = 2048;
	localparam int BOOST_HALF  = CLK_HZ / (2 * BOOST_HZ);
	localparam int SETTLE_MS   = 100;
	localparam int SETTLE_CYC  = (CLK_HZ / 1000) * SETTLE_MS;

	// Regulator settings as seen by the analog side
	typedef struct packed {
		logic       lcd_regulator_on;
		logic       reference_level_select;
		logic       core_reg_heavy_load;
		logic       lcd_reg_heavy_load;
		logic [1:0] boost_clock_select;
		logic [1:0] frame_rate_select;
	} lrp_ctrl_t;

	// Drive-level enables; zero means held at ground
	typedef struct packed {
		logic level3;
		logic level2;
		logic level1;
	} lrp_levels_t;

endpackage

`default_nettype wire

// *** core/lrp_boost_div.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Boost clock divider
// ****************************************************************
module lrp_boost_div #(
	parameter int HALF = lrp_pkg::BOOST_HALF
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      tick
);
	localparam int W = $clog2(HALF + 1);
	logic [W-1:0] cnt_q;

	// Half-period enable pulse, counter parked while stopped
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (!run) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (cnt_q == W'(HALF - 1)) begin
			cnt_q <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + W'(1);
			tick  <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// *** verification/lrp_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// *******
// Register and output checker
// *******
module lrp_asserts (
	input wire logic                 core_clk,
	input wire logic                 rst_n,
	input wire logic [15:0]          reg_addr,
	input wire logic [3:0]           reg_wdata,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [3:0]           reg_rdata,
	input wire lrp_pkg::lrp_ctrl_t   ctrl,
	input wire lrp_pkg::lrp_levels_t lcd_drive_levels,
	input wire logic                 boost_clk,
	input wire logic                 core_supply_out,
	input wire logic                 levels_settled
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Power control bits in register order
	wire [3:0] pwr = {ctrl.lcd_reg_heavy_load, ctrl.core_reg_heavy_load,
		ctrl.reference_level_select, ctrl.lcd_regulator_on};
	wire [3:0] frm = {ctrl.frame_rate_select, ctrl.boost_clock_select};
	wire       pa  = reg_addr == lrp_pkg::PWR_CTRL_ADDR;
	wire       fa  = reg_addr == lrp_pkg::FRAME_CLK_ADDR;
	sequence s_wp; reg_wr && pa; endsequence
	sequence s_wf; reg_wr && fa; endsequence
	// Properties
	property p_supply; core_supply_out; endproperty
	property p_wp; s_wp |-> ##2 pwr == $past(reg_wdata, 2); endproperty
	property p_wf; s_wf |-> ##2 frm == $past(reg_wdata, 2); endproperty
	property p_rp; reg_rd && pa |=> reg_rdata == pwr; endproperty
	property p_rf; reg_rd && fa |=> reg_rdata == frm; endproperty
	property p_r0; !(reg_rd && (pa || fa)) |=> reg_rdata == 4'h0; endproperty
	property p_lvl; lcd_drive_levels == {3{ctrl.lcd_regulator_on}}; endproperty
	property p_bst; (ctrl.boost_clock_select != lrp_pkg::BOOST_ON)[*2] |-> !boost_clk; endproperty
	property p_set; $rose(ctrl.lcd_regulator_on) |-> !levels_settled[*8]; endproperty
	a_supply: assert property (p_supply) else $error("core supply low");
	a_wp: assert property (p_wp) else $error("power bits wrong");
	a_wf: assert property (p_wf) else $error("boost field wrong");
	a_rp: assert property (p_rp) else $error("power readback");
	a_rf: assert property (p_rf) else $error("boost readback");
	a_r0: assert property (p_r0) else $error("read data not zero");
	a_lvl: assert property (p_lvl) else $error("drive levels wrong");
	a_bst: assert property (p_bst) else $error("boost clock runs");
	a_set: assert property (p_set) else $error("settled too early");
endmodule
bind lrp_top lrp_asserts lrp_asserts_inst (.core_clk(core_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .ctrl(ctrl), .lcd_drive_levels(lcd_drive_levels),
	.boost_clk(boost_clk), .core_supply_out(core_supply_out),
	.levels_settled(levels_settled));
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// *******
// Bench
// *******
module tb_top;
	logic                 core_clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic [15:0]          reg_addr = 16'h0000;
	logic [15:0]          a;
	logic [3:0]           reg_wdata = 4'h0;
	logic                 reg_wr = 1'b0;
	logic                 reg_rd = 1'b0;
	logic [3:0]           reg_rdata, pm, fm, v;
	lrp_pkg::lrp_ctrl_t   ctrl;
	lrp_pkg::lrp_levels_t lcd_drive_levels;
	logic                 boost_clk, core_supply_out, levels_settled;
	logic [31:0]          rs = 32'h0000005d;
	int                   miscompares = 0, samples_checked = 0, i;
	// Clock
	always #20 core_clk = ~core_clk;
	lrp_top #(.SETTLE_CYC(20)) lrp_top_inst (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ctrl(ctrl), .lcd_drive_levels(lcd_drive_levels),
		.boost_clk(boost_clk), .core_supply_out(core_supply_out),
		.levels_settled(levels_settled));
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] t;
		t = x ^ (x << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [3:0] expv(input logic [15:0] ad);
		return ad == lrp_pkg::PWR_CTRL_ADDR ? pm : ad == lrp_pkg::FRAME_CLK_ADDR ? fm : 4'h0;
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic results();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic tmo(input int n);
		if (i >= n) begin
			miscompares++;
			results();
		end
	endtask
	task automatic wr(input logic [15:0] ad, input logic [3:0] d);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		if (ad == lrp_pkg::PWR_CTRL_ADDR) pm = d;
		if (ad == lrp_pkg::FRAME_CLK_ADDR) fm = d;
	endtask
	task automatic rd(input logic [15:0] ad);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, expv(ad));
		chk(ctrl, {pm[0], pm[1], pm[2], pm[3], fm[1:0], fm[3:2]});
		chk(lcd_drive_levels, {3{pm[0]}});
		chk(core_supply_out, 1'b1);
	endtask
	// Main sequence
	initial begin
		pm = 4'h0;
		fm = 4'h0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 44; i++) begin
			rs = xs(rs);
			a = rs[17:16] == 2'h0 ? rs[31:16] : rs[16] ? lrp_pkg::PWR_CTRL_ADDR : lrp_pkg::FRAME_CLK_ADDR;
			if (i < 2) rd(i == 0 ? lrp_pkg::PWR_CTRL_ADDR : lrp_pkg::FRAME_CLK_ADDR);
			else wr(a, rs[3:0]);
			if (i >= 2) rd(a);
		end
		wr(lrp_pkg::FRAME_CLK_ADDR, 4'h1);
		wr(lrp_pkg::PWR_CTRL_ADDR, 4'h1);
		for (i = 0; i < 40 && levels_settled !== 1'b1; i++) @(posedge core_clk);
		tmo(40);
		for (i = 0; i < 13000 && boost_clk !== 1'b1; i++) @(posedge core_clk);
		tmo(13000);
		wr(lrp_pkg::FRAME_CLK_ADDR, 4'h2);
		rd(lrp_pkg::FRAME_CLK_ADDR);
		#1 chk(boost_clk, 1'b0);
		wr(lrp_pkg::PWR_CTRL_ADDR, 4'h0);
		wr(lrp_pkg::FRAME_CLK_ADDR, 4'h0);
		rd(lrp_pkg::PWR_CTRL_ADDR);
		wr(lrp_pkg::PWR_CTRL_ADDR, 4'hf);
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		pm = 4'h0;
		fm = 4'h0;
		rd(lrp_pkg::PWR_CTRL_ADDR);
		rd(lrp_pkg::FRAME_CLK_ADDR);
		results();
	end
endmodule
`default_nettype wire
